// File: logic/sbrg_pkg.sv
// Constants for the serial baud rate generator
package sbrg_pkg;
  localparam int          DIV_W         = 12;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;
  localparam int          HI_W          = 4;
  localparam logic [3:0]  ADDR_DIV_HIGH = 4'h1;
  localparam logic [3:0]  ADDR_DIV_LOW  = 4'h0;
  localparam logic [3:0]  ADDR_CTRL     = 4'h2;
  localparam logic [3:0]  ADDR_STATUS   = 4'h3;
  localparam logic [11:0] DIV_RESET     = 12'h000;
  localparam logic [3:0]  OVS_RESET     = 4'h0;
  localparam logic [3:0]  OVS_NORMAL    = 4'hF;
  localparam logic [3:0]  OVS_DOUBLE    = 4'h7;
  localparam int          CTRL_DS_BIT   = 0;
  localparam logic [7:0]  READ_ZERO     = 8'h00;
endpackage

// File: logic/sbrg_baud_gen.sv
// Baud rate generator with divisor registers and double speed control
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module sbrg_baud_gen
  import sbrg_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWrStb,
  input  wire logic              regRdStb,
  output var  logic [DATA_W-1:0] regRdData,
  output var  logic              sampleTick,
  output var  logic              bitTick
);

  ////////////////////////////////////////////////////////////////////////////
  logic [HI_W-1:0]   divHigh_ff, nxt_divHigh;
  logic [DATA_W-1:0] divLow_ff, nxt_divLow;
  logic              doubleSpeed_ff, nxt_doubleSpeed;
  logic [DIV_W-1:0]  presc_ff, nxt_presc;
  logic [3:0]        ovs_ff, nxt_ovs;
  logic              sampleTick_ff, nxt_sampleTick;
  logic              bitTick_ff, nxt_bitTick;
  logic [DATA_W-1:0] rdData_ff, nxt_rdData;
  logic [DIV_W-1:0]  baudDivisor;
  logic              lowWrite;
  // Checking aid only: sample ticks counted between bit boundaries
  logic [3:0]        tickCnt_ff, nxt_tickCnt;
  logic              bitMode_ff, nxt_bitMode;
  logic              seenBit_ff, nxt_seenBit;

  assign baudDivisor = {divHigh_ff, divLow_ff};
  assign lowWrite    = regWrStb && (regAddr == ADDR_DIV_LOW);

  ////////////////////////////////////////////////////////////////////////////
  // Register file; divisor changes mid-frame are not guarded
  always_comb begin
    nxt_divHigh     = divHigh_ff;
    nxt_divLow      = divLow_ff;
    nxt_doubleSpeed = doubleSpeed_ff;
    nxt_rdData      = READ_ZERO;
    if (regWrStb) begin
      case (regAddr)
        ADDR_DIV_HIGH: nxt_divHigh = regWrData[HI_W-1:0];
        ADDR_DIV_LOW:  nxt_divLow = regWrData;
        ADDR_CTRL:     nxt_doubleSpeed = regWrData[CTRL_DS_BIT];
        default:       nxt_divLow = divLow_ff;
      endcase
    end
    if (regRdStb) begin
      case (regAddr)
        ADDR_DIV_HIGH: nxt_rdData = {{(DATA_W-HI_W){1'b0}}, divHigh_ff};
        ADDR_DIV_LOW:  nxt_rdData = divLow_ff;
        ADDR_CTRL:     nxt_rdData = {{(DATA_W-1){1'b0}}, doubleSpeed_ff};
        ADDR_STATUS:   nxt_rdData = {{(DATA_W-4){1'b0}}, ovs_ff};
        default:       nxt_rdData = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divHigh_ff     <= DIV_RESET[DIV_W-1:DATA_W];
      divLow_ff      <= DIV_RESET[DATA_W-1:0];
      doubleSpeed_ff <= 1'b0;
      rdData_ff      <= READ_ZERO;
    end else begin
      divHigh_ff     <= nxt_divHigh;
      divLow_ff      <= nxt_divLow;
      doubleSpeed_ff <= nxt_doubleSpeed;
      rdData_ff      <= nxt_rdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler and oversampling counter
  always_comb begin
    nxt_presc      = presc_ff;
    nxt_ovs        = ovs_ff;
    nxt_sampleTick = 1'b0;
    nxt_bitTick    = 1'b0;
    if (lowWrite) begin
      nxt_presc = {divHigh_ff, regWrData};
    end else if (presc_ff == DIV_RESET) begin
      nxt_presc      = baudDivisor;
      nxt_sampleTick = 1'b1;
      if (ovs_ff == OVS_RESET) begin
        nxt_ovs     = doubleSpeed_ff ? OVS_DOUBLE : OVS_NORMAL;
        nxt_bitTick = 1'b1;
      end else begin
        nxt_ovs = ovs_ff - 4'h1;
      end
    end else begin
      nxt_presc = presc_ff - 12'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff      <= DIV_RESET;
      ovs_ff        <= OVS_RESET;
      sampleTick_ff <= 1'b0;
      bitTick_ff    <= 1'b0;
    end else begin
      presc_ff      <= nxt_presc;
      ovs_ff        <= nxt_ovs;
      sampleTick_ff <= nxt_sampleTick;
      bitTick_ff    <= nxt_bitTick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample ticks between two bit ticks, with the speed chosen at the boundary
  always_comb begin
    nxt_tickCnt = tickCnt_ff;
    nxt_bitMode = bitMode_ff;
    nxt_seenBit = seenBit_ff;
    if (nxt_bitTick) begin
      nxt_tickCnt = OVS_RESET;
      nxt_bitMode = doubleSpeed_ff;
      nxt_seenBit = 1'b1;
    end else if (nxt_sampleTick) begin
      nxt_tickCnt = tickCnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_ff <= OVS_RESET;
      bitMode_ff <= 1'b0;
      seenBit_ff <= 1'b0;
    end else begin
      tickCnt_ff <= nxt_tickCnt;
      bitMode_ff <= nxt_bitMode;
      seenBit_ff <= nxt_seenBit;
    end
  end

  assign regRdData  = rdData_ff;
  assign sampleTick = sampleTick_ff;
  assign bitTick    = bitTick_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register checks
  chk_div_concat: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRdStb && regAddr == ADDR_DIV_HIGH |=> regRdData == {4'h0, $past(baudDivisor[11:8])})
    else $error("high byte read mismatch");

  chk_low_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRdStb && regAddr == ADDR_DIV_LOW |=> regRdData == $past(divLow_ff))
    else $error("low byte read mismatch");

  chk_high_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regWrStb && regAddr == ADDR_DIV_HIGH |=> divHigh_ff == $past(regWrData[3:0]))
    else $error("high byte write lost");

  chk_high_reserved: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRdStb && regAddr == ADDR_DIV_HIGH |=> regRdData[7:4] == 4'h0)
    else $error("reserved bits not zero");

  chk_reset_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(rst_n) |-> baudDivisor == DIV_RESET && regRdData == READ_ZERO)
    else $error("divisor not zero after reset");

  chk_speed_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regRdStb && regAddr == ADDR_CTRL |=> regRdData == {7'h00, $past(doubleSpeed_ff)})
    else $error("speed control read mismatch");

  // Prescaler and oversampling checks
  chk_low_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lowWrite |=> presc_ff == {divHigh_ff, divLow_ff})
    else $error("low write did not reload prescaler");

  chk_reload_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lowWrite |=> !sampleTick)
    else $error("reload emitted a tick");

  chk_high_no_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
    regWrStb && regAddr == ADDR_DIV_HIGH && presc_ff != DIV_RESET |=>
      presc_ff == $past(presc_ff) - 12'h001)
    else $error("high write disturbed prescaler");

  chk_zero_rate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(presc_ff == DIV_RESET) && !$past(lowWrite) &&
      $past(baudDivisor == DIV_RESET) |-> sampleTick && presc_ff == DIV_RESET)
    else $error("zero divisor not ticking every cycle");

  chk_double_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nxt_bitTick |=> ovs_ff == ($past(doubleSpeed_ff) ? OVS_DOUBLE : OVS_NORMAL))
    else $error("oversampling reload wrong");

  chk_bit_on_sample: assert property (@(posedge clk_sys) disable iff (!rst_n)
    bitTick |-> sampleTick)
    else $error("bit tick without sample tick");

  chk_bit_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    nxt_bitTick && seenBit_ff |-> tickCnt_ff == (bitMode_ff ? OVS_DOUBLE : OVS_NORMAL))
    else $error("wrong sample ticks per bit");

  chk_presc_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !lowWrite && presc_ff != DIV_RESET |=> presc_ff == $past(presc_ff) - 12'h001)
    else $error("prescaler not counting down");

  chk_tick_single: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sampleTick && $past(baudDivisor) != DIV_RESET |-> ##1 !sampleTick)
    else $error("tick longer than one cycle");

  chk_tick_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sampleTick && $past(baudDivisor) == 12'h002 && !lowWrite) ##1 !lowWrite[*2] |->
      $past(!sampleTick) && !sampleTick ##1 sampleTick)
    else $error("prescaler period not divisor plus one");

endmodule // sbrg_baud_gen

`default_nettype wire

// File: verif/sbrg_tb.sv
// Self-checking bench for the serial baud rate generator
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module testbench
  import sbrg_pkg::*;
;
  logic              clk_sys, rst_n, regWrStb, regRdStb, sampleTick, bitTick;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData;
  int                n_mismatch, compares, cycles, w, n;
  sbrg_baud_gen i_sbrg_baud_gen (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .sampleTick(sampleTick), .bitTick(bitTick));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end
  task finish_test();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask
  task rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1 `CHK("regRdData", e, regRdData)
  endtask
  // Cycles waited for a tick in w, then cycles to the next tick in n
  task per(input logic isBit);
    #1 w = 0;
    n = 0;
    while ((isBit ? bitTick : sampleTick) !== 1'b1 && w < 5000) begin
      @(posedge clk_sys);
      #1 w++;
    end
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while ((isBit ? bitTick : sampleTick) !== 1'b1 && n < 5000);
  endtask
  initial begin
    rst_n = 1'b0;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
    regAddr = '0;
    regWrData = '0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(ADDR_DIV_LOW, 8'h00);
    rd(ADDR_DIV_HIGH, 8'h00);
    per(1'b0); `CHK("sample period", 1, n)
    per(1'b1); per(1'b1); `CHK("bit period", 16, n)
    $display("test reset done");
    wr(ADDR_DIV_HIGH, 8'h0F); rd(ADDR_DIV_HIGH, 8'h0F);
    wr(ADDR_DIV_HIGH, 8'h01); wr(ADDR_DIV_LOW, 8'h00);
    per(1'b0); per(1'b0); `CHK("sample period", 257, n)
    wr(ADDR_DIV_HIGH, 8'h00); wr(ADDR_DIV_LOW, 8'h02);
    per(1'b0); `CHK("reload wait", 1'b1, (w <= 4))
    `CHK("sample period", 3, n)
    $display("test divisor done");
    per(1'b1); per(1'b1); `CHK("bit period", 48, n)
    wr(ADDR_CTRL, 8'h01);
    rd(ADDR_CTRL, 8'h01);
    per(1'b1); per(1'b1); `CHK("bit period", 24, n)
    rd(4'h9, READ_ZERO);
    $display("test speed done");
    finish_test();
  end
endmodule // testbench
`default_nettype wire
